// file: rtl/ccd_seq_cfg.svh
/*
  Timing and geometry constants for the full-frame CCD readout sequencer.
  Assumes a 10 MHz system clock; counts are derived from times in ns.
*/
`ifndef CCD_SEQ_CFG_SVH
`define CCD_SEQ_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and geometry
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define ACTIVE_COLS 512
`define ACTIVE_ROWS 512
`define DARK_PIX_LEAD 4
`define DARK_PIX_TRAIL 8
`define DARK_LINES_TOP 4
`define DARK_LINES_BOT 4
`define PIX_PER_LINE (`DARK_PIX_LEAD + `ACTIVE_COLS + `DARK_PIX_TRAIL)
`define LINES_PER_FRAME (`DARK_LINES_TOP + `ACTIVE_ROWS + `DARK_LINES_BOT)

// ----------------------------------------------------------------------------
// Times and derived cycle counts
// ----------------------------------------------------------------------------
`define PIX_PERIOD_MIN_NS 125
`define PIX_PERIOD_NOM_NS 200
`define RESET_PULSE_MIN_NS 10
`define RESET_PULSE_NOM_NS 20
`define VPULSE_NOM_NS 5000
`define HSETUP_NOM_NS 1000
// Nominal times round up to whole cycles, never below one.
`define CEIL_CYC(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define PIX_CYC `CEIL_CYC(`PIX_PERIOD_NOM_NS)
`define RST_CYC `CEIL_CYC(`RESET_PULSE_NOM_NS)
`define VPH_CYC `CEIL_CYC(`VPULSE_NOM_NS)
`define HSETUP_CYC `CEIL_CYC(`HSETUP_NOM_NS)

`endif

// file: rtl/ccd_seq_pkg.sv
/*
  Types shared by the CCD readout sequencer.
  Assumes ccd_seq_cfg.svh supplies the numeric constants.
*/
package ccd_seq_pkg;
  // Readout sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXPOSE,
    ST_V_MERGE,
    ST_V_SWAP,
    ST_V_ADV,
    ST_H_SETUP,
    ST_H_READ
  } seq_state_t;
endpackage

// file: rtl/phase_timer.sv
/*
  Down counter used to pace the exposure, vertical-shift and horizontal set-up phases of the sequencer.
  Assumes a single clock; load and count share that clock.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,               // System clock.
  input wire logic i_rst,               // Asynchronous reset, active high.
  input wire logic i_load,              // Load a new count.
  input wire logic [WIDTH-1:0] i_count, // Cycles to wait, at least one.
  output logic o_done                   // High while the timer has expired.
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  // Load, then count down to zero and hold.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_load) begin
      nxt_cnt = i_count - WIDTH'(1);
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - WIDTH'(1);
    end
  end

  // Count register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Expiry is taken from the count alone: the caller loads on expiry, so a
  // term on i_load here would close a combinational loop through the caller.
  assign o_done = (cnt_ff == '0);
endmodule
`default_nettype wire

// file: rtl/ccd_readout_seq.sv
/*
  Readout sequencer that drives a two-phase full-frame CCD through its clock
  pins: vertical shift, complementary horizontal readout, split-gate output
  selection and the reset-gate pulse after each sample.
  Assumes external level shifters translate the logic levels to gate voltages
  and that an external ADC samples the video while o_sample is high.
*/
`include "ccd_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_seq (
  input wire logic i_clk,            // System clock, 10 MHz.
  input wire logic i_rst,            // Asynchronous reset, active high.
  input wire logic i_start,          // Pulse: start exposure and readout.
  input wire logic i_sel_high_sens,  // Level: 1 selects the high-sensitivity output.
  input wire logic [23:0] i_expose_cycles, // Exposure length in clock cycles.
  output logic o_vertical_phase_a,   // Vertical phase a.
  output logic o_vertical_phase_b,   // Vertical phase b.
  output logic o_horizontal_phase_a, // Horizontal phase a.
  output logic o_horizontal_phase_b, // Horizontal phase b.
  output logic o_split_gate_low_gain_path,  // Split gate to wide-range output.
  output logic o_split_gate_high_gain_path, // Split gate to high-gain output.
  output logic o_reset_gate,         // Reset gate pulse.
  output logic o_sample,             // High while the video is valid to sample.
  output logic o_shutter_open,       // High while light may reach the array.
  output logic o_busy,               // High from start until the frame ends.
  output logic o_frame_done          // One-cycle pulse at the end of a frame.
);
  localparam int PIX_W = 10;
  localparam int LINE_W = 10;
  localparam int TMR_W = 24;
  localparam logic [PIX_W-1:0] PIX_LAST = PIX_W'(`PIX_PER_LINE - 1);
  localparam logic [LINE_W-1:0] LINE_LAST = LINE_W'(`LINES_PER_FRAME - 1);
  // Pixel slot: cycle 0 phase a high; cycle 1 phase b high; cycle 2 sample,
  // cycle 3 reset pulse; phase b falls (packet dumped) after cycle 4.
  localparam int PIX_SLOT = (`PIX_CYC < 5) ? 5 : `PIX_CYC;
  localparam logic [2:0] SLOT_LAST = 3'(PIX_SLOT - 1);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ccd_seq_pkg::seq_state_t state_ff, nxt_state;
  logic [PIX_W-1:0] pix_ff, nxt_pix;
  logic [LINE_W-1:0] line_ff, nxt_line;
  logic [2:0] slot_ff, nxt_slot;
  logic sens_ff, nxt_sens;
  logic va_ff, nxt_va, vb_ff, nxt_vb;
  logic ha_ff, nxt_ha, hb_ff, nxt_hb;
  logic rg_ff, nxt_rg, smp_ff, nxt_smp;
  logic shut_ff, nxt_shut, busy_ff, nxt_busy, done_ff, nxt_done;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic tmr_done;

  // Paces exposure, vertical phases and horizontal set-up.
  phase_timer #(.WIDTH(TMR_W)) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(tmr_done)
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Walks exposure, the three-step vertical shift and the line readout.
  always_comb begin
    nxt_state = state_ff;
    nxt_pix = pix_ff;
    nxt_line = line_ff;
    nxt_slot = slot_ff;
    nxt_sens = sens_ff;
    nxt_va = va_ff;
    nxt_vb = vb_ff;
    nxt_ha = ha_ff;
    nxt_hb = hb_ff;
    nxt_rg = 1'b0;
    nxt_smp = 1'b0;
    nxt_shut = shut_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    tmr_load = 1'b0;
    tmr_count = TMR_W'(`VPH_CYC);
    unique case (state_ff)
      ccd_seq_pkg::ST_IDLE: begin
        nxt_ha = 1'b0;
        nxt_hb = 1'b1;
        if (i_start) begin
          nxt_sens = i_sel_high_sens;  // Output choice fixed for the frame.
          nxt_state = ccd_seq_pkg::ST_EXPOSE;
          nxt_va = 1'b0;
          nxt_vb = 1'b0;
          nxt_shut = 1'b1;
          nxt_busy = 1'b1;
          nxt_line = '0;
          tmr_load = 1'b1;
          tmr_count = (i_expose_cycles == '0) ? TMR_W'(1) : i_expose_cycles;
        end
      end
      ccd_seq_pkg::ST_EXPOSE: begin
        if (tmr_done) begin
          nxt_shut = 1'b0;
          nxt_va = 1'b1;
          nxt_state = ccd_seq_pkg::ST_V_MERGE;
          tmr_load = 1'b1;
        end
      end
      ccd_seq_pkg::ST_V_MERGE: begin
        if (tmr_done) begin
          nxt_va = 1'b0;               // Phases swap polarity.
          nxt_vb = 1'b1;
          nxt_state = ccd_seq_pkg::ST_V_SWAP;
          tmr_load = 1'b1;
        end
      end
      ccd_seq_pkg::ST_V_SWAP: begin
        if (tmr_done) begin
          nxt_va = 1'b1;               // Second transition.
          nxt_vb = 1'b0;               // Falling edge moves the row.
          nxt_state = ccd_seq_pkg::ST_V_ADV;
          tmr_load = 1'b1;
        end
      end
      ccd_seq_pkg::ST_V_ADV: begin
        if (tmr_done) begin
          nxt_va = 1'b0;
          nxt_state = ccd_seq_pkg::ST_H_SETUP;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(`HSETUP_CYC);
        end
      end
      ccd_seq_pkg::ST_H_SETUP: begin
        if (tmr_done) begin
          nxt_state = ccd_seq_pkg::ST_H_READ;
          nxt_pix = '0;
          nxt_slot = '0;
          nxt_ha = 1'b1;
          nxt_hb = 1'b0;
        end
      end
      ccd_seq_pkg::ST_H_READ: begin
        nxt_slot = (slot_ff == SLOT_LAST) ? 3'h0 : slot_ff + 3'h1;
        if (slot_ff == 3'h0) begin
          nxt_ha = 1'b0;
          nxt_hb = 1'b1;
        end
        if (slot_ff == 3'h1) begin
          nxt_smp = 1'b1;              // Sample the video next cycle.
        end
        if (slot_ff == 3'h2) begin
          nxt_rg = 1'b1;               // Reset after sampling.
        end
        if (slot_ff == SLOT_LAST) begin
          if (pix_ff == PIX_LAST) begin
            nxt_ha = 1'b0;
            nxt_hb = 1'b1;
            if (line_ff == LINE_LAST) begin
              nxt_state = ccd_seq_pkg::ST_IDLE;
              nxt_busy = 1'b0;
              nxt_done = 1'b1;
            end else begin
              nxt_line = line_ff + LINE_W'(1);
              nxt_va = 1'b1;           // Next line shift.
              nxt_state = ccd_seq_pkg::ST_V_MERGE;
              tmr_load = 1'b1;
            end
          end else begin
            nxt_pix = pix_ff + PIX_W'(1);
            nxt_ha = 1'b1;
            nxt_hb = 1'b0;
          end
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Holds the sequencer state and every pin level except the split gates.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ccd_seq_pkg::ST_IDLE;
      pix_ff <= '0;
      line_ff <= '0;
      slot_ff <= '0;
      sens_ff <= 1'b0;
      va_ff <= 1'b0;
      vb_ff <= 1'b0;
      ha_ff <= 1'b0;
      hb_ff <= 1'b1;
      rg_ff <= 1'b0;
      smp_ff <= 1'b0;
      shut_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pix_ff <= nxt_pix;
      line_ff <= nxt_line;
      slot_ff <= nxt_slot;
      sens_ff <= nxt_sens;
      va_ff <= nxt_va;
      vb_ff <= nxt_vb;
      ha_ff <= nxt_ha;
      hb_ff <= nxt_hb;
      rg_ff <= nxt_rg;
      smp_ff <= nxt_smp;
      shut_ff <= nxt_shut;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  // Split gates: one follows phase b, the other stays at the blocking level.
  logic gl_ff, gh_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gl_ff <= 1'b0;
      gh_ff <= 1'b0;
    end else begin
      gl_ff <= nxt_sens ? 1'b0 : nxt_hb;
      gh_ff <= nxt_sens ? nxt_hb : 1'b0;
    end
  end

  // Pin outputs straight from flip-flops.
  assign o_vertical_phase_a = va_ff;
  assign o_vertical_phase_b = vb_ff;
  assign o_horizontal_phase_a = ha_ff;
  assign o_horizontal_phase_b = hb_ff;
  assign o_split_gate_low_gain_path = gl_ff;
  assign o_split_gate_high_gain_path = gh_ff;
  assign o_reset_gate = rg_ff;
  assign o_sample = smp_ff;
  assign o_shutter_open = shut_ff;
  assign o_busy = busy_ff;
  assign o_frame_done = done_ff;
endmodule
`default_nettype wire

// file: dv/ccd_seq_chk_sva.sv
/* Assertions on the readout sequencer pins.
   Assumes a bind onto ccd_readout_seq and sight of its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ccd_seq_chk (
  input wire logic i_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic o_vertical_phase_a, // Pin.
  input wire logic o_vertical_phase_b, // Pin.
  input wire logic o_horizontal_phase_a, // Pin.
  input wire logic o_horizontal_phase_b, // Pin.
  input wire logic o_split_gate_low_gain_path, // Pin.
  input wire logic o_split_gate_high_gain_path, // Pin.
  input wire logic o_reset_gate, // Pin.
  input wire logic o_sample, // Pin.
  input wire logic o_shutter_open, // Pin.
  input wire logic o_busy // Pin.
);
  // Short aliases keep the properties readable.
  wire va = o_vertical_phase_a;
  wire vb = o_vertical_phase_b;
  wire hb = o_horizontal_phase_b;
  wire sgl = o_split_gate_low_gain_path;
  wire sgh = o_split_gate_high_gain_path;
  logic [7:0] va_len_ff;
  logic [7:0] nxt_va_len;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Counts how long vertical phase a has stood high.
  always_comb begin
    nxt_va_len = va ? va_len_ff + 8'h01 : 8'h00;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      va_len_ff <= 8'h00;
    end else begin
      va_len_ff <= nxt_va_len;
    end
  end
  property p_h_compl; o_horizontal_phase_a != hb; endproperty
  a_h_compl: assert property (p_h_compl) else $error("horizontal phases equal");
  property p_sg_sub; (sgl || sgh) |-> hb && !(sgl && sgh); endproperty
  a_sg_sub: assert property (p_sg_sub) else $error("split gate off phase b");
  property p_sg_sel; o_sample |-> sgl || sgh; endproperty
  a_sg_sel: assert property (p_sg_sel) else $error("no split gate clocking");
  property p_smp_rg; o_sample |=> o_reset_gate && !o_sample; endproperty
  a_smp_rg: assert property (p_smp_rg) else $error("no reset after sample");
  property p_rg_cause; $rose(o_reset_gate) |-> $past(o_sample); endproperty
  a_rg_cause: assert property (p_rg_cause) else $error("reset without sample");
  property p_pix; $fell(hb) |=> (!$fell(hb))[*4]; endproperty
  a_pix: assert property (p_pix) else $error("pixel period short");
  property p_push; $fell(hb) |-> ##[1:3] o_sample; endproperty
  a_push: assert property (p_push) else $error("packet not sampled");
  property p_expose; o_shutter_open |-> !va && !vb && !o_sample; endproperty
  a_expose: assert property (p_expose) else $error("clocking while exposed");
  property p_swap; $rose(vb) |-> $fell(va); endproperty
  a_swap: assert property (p_swap) else $error("vertical swap broken");
  property p_va_len; $fell(va) && !$past(i_rst) |-> va_len_ff == 8'h32; endproperty
  a_va_len: assert property (p_va_len) else $error("vertical step length");
  property p_vstill; o_sample |-> !va && !vb; endproperty
  a_vstill: assert property (p_vstill) else $error("vertical move in readout");
  c_low: cover property (o_sample && sgl);
  c_high: cover property (o_sample && sgh);
  c_row: cover property ($fell(vb));
endmodule
bind ccd_readout_seq ccd_seq_chk chk_u (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .o_vertical_phase_a(o_vertical_phase_a),
  .o_vertical_phase_b(o_vertical_phase_b),
  .o_horizontal_phase_a(o_horizontal_phase_a),
  .o_horizontal_phase_b(o_horizontal_phase_b),
  .o_split_gate_low_gain_path(o_split_gate_low_gain_path),
  .o_split_gate_high_gain_path(o_split_gate_high_gain_path),
  .o_reset_gate(o_reset_gate),
  .o_sample(o_sample),
  .o_shutter_open(o_shutter_open),
  .o_busy(o_busy)
);
`default_nettype wire

// file: dv/ccd_array_model.sv
/* Behavioural model of the full-frame array: moves rows and counts packets.
   Assumes logic-level gate clocks sampled on the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module ccd_array_model (
  input wire logic i_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic i_vertical_phase_b, // Vertical phase b.
  input wire logic i_horizontal_phase_b, // Horizontal phase b.
  input wire logic i_split_gate_low_gain_path, // Split gate, wide range.
  input wire logic i_split_gate_high_gain_path, // Split gate, high gain.
  output logic [9:0] o_rows, // Rows moved into the horizontal register.
  output logic [9:0] o_line_pix // Packets pushed out of the previous line.
);
  logic vb_q, hb_q, sg_q;
  logic [9:0] pix_cnt;
  // Rows drop on vertical b falling; packets leave on horizontal b falling.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vb_q <= 1'b0;
      hb_q <= 1'b1;
      sg_q <= 1'b0;
      pix_cnt <= 10'h000;
      o_rows <= 10'h000;
      o_line_pix <= 10'h000;
    end else begin
      vb_q <= i_vertical_phase_b;
      hb_q <= i_horizontal_phase_b;
      sg_q <= i_split_gate_low_gain_path | i_split_gate_high_gain_path;
      if (vb_q && !i_vertical_phase_b) begin
        o_rows <= o_rows + 10'h001;
        o_line_pix <= pix_cnt;
        pix_cnt <= 10'h000;
      end else if (hb_q && !i_horizontal_phase_b && sg_q) begin
        pix_cnt <= pix_cnt + 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/ccd_readout_seq_tb.sv
/* Self-checking bench for the readout sequencer driving an array model.
   Assumes the design, the checker and ccd_array_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_seq_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic i_sel_high_sens = 1'b0;
  logic [23:0] i_expose_cycles = 24'h000014;
  logic o_vertical_phase_a, o_vertical_phase_b, o_horizontal_phase_a, o_horizontal_phase_b;
  logic o_split_gate_low_gain_path, o_split_gate_high_gain_path, o_reset_gate, o_sample;
  logic o_shutter_open, o_busy, o_frame_done;
  logic [9:0] rows;
  logic [9:0] line_pix;
  int miscompares = 0;
  int n_checks = 0;
  wire [2:0] code = {o_shutter_open, o_vertical_phase_a, o_vertical_phase_b};
  // Free-running 10 MHz clock.
  always #50 i_clk = ~i_clk;
  ccd_readout_seq dut_u (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(i_start),
    .i_sel_high_sens(i_sel_high_sens),
    .i_expose_cycles(i_expose_cycles),
    .o_vertical_phase_a(o_vertical_phase_a),
    .o_vertical_phase_b(o_vertical_phase_b),
    .o_horizontal_phase_a(o_horizontal_phase_a),
    .o_horizontal_phase_b(o_horizontal_phase_b),
    .o_split_gate_low_gain_path(o_split_gate_low_gain_path),
    .o_split_gate_high_gain_path(o_split_gate_high_gain_path),
    .o_reset_gate(o_reset_gate),
    .o_sample(o_sample),
    .o_shutter_open(o_shutter_open),
    .o_busy(o_busy),
    .o_frame_done(o_frame_done)
  );
  ccd_array_model model_u (.i_clk(i_clk), .i_rst(i_rst), .i_vertical_phase_b(o_vertical_phase_b),
    .i_horizontal_phase_b(o_horizontal_phase_b), .i_split_gate_low_gain_path(o_split_gate_low_gain_path),
    .i_split_gate_high_gain_path(o_split_gate_high_gain_path), .o_rows(rows), .o_line_pix(line_pix));
  task end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  task do_reset;
    i_rst = 1'b1;
    tick(10);
    i_rst = 1'b0;
  endtask
  // Waits, bounded, for a given shutter and vertical pattern.
  task wait_code(input logic [2:0] c);
    int n;
    n = 0;
    while (code !== c) begin
      n++;
      if (n > 4000) begin
        miscompares++;
        end_of_test();
      end
      tick(1);
    end
  endtask
  // Measures how many cycles a pattern stands once it appears.
  task run_len(input logic [2:0] c, input int exp, input string name);
    int n;
    n = 0;
    wait_code(c);
    while (code === c && n < 4000) begin
      n++;
      tick(1);
    end
    check(name, n, exp);
  endtask
  // Every output except the wide-range split gate settles to its idle level under reset.
  task reset_values;
    do_reset();
    check("idle", {code, o_horizontal_phase_a, o_horizontal_phase_b, o_split_gate_low_gain_path,
      o_split_gate_high_gain_path, o_reset_gate, o_sample, o_busy, o_frame_done}, 11'h040);
    tick(2);
    // Once clocked, the wide-range split gate follows horizontal phase b.
    check("idle_run", {code, o_horizontal_phase_a, o_horizontal_phase_b, o_split_gate_low_gain_path,
      o_split_gate_high_gain_path, o_reset_gate, o_sample, o_busy, o_frame_done}, 11'h060);
  endtask
  // One exposure, two line shifts and a full line, in the given output mode.
  task frame_mode(input logic sens);
    int n;
    int ns;
    do_reset();
    i_sel_high_sens = sens;
    i_start = 1'b1;
    tick(1);
    i_start = 1'b0;
    wait_code(3'b100);
    i_start = 1'b1;
    run_len(3'b100, 20, "expose");
    i_start = 1'b0;
    check("busy", o_busy, 1'b1);
    run_len(3'b010, 50, "merge");
    run_len(3'b001, 50, "swap");
    run_len(3'b010, 50, "advance");
    check("rows1", rows, 10'h001);
    n = 0;
    ns = 0;
    while (code === 3'b000 && n < 4000) begin
      if (o_sample === 1'b1) begin
        ns++;
        check("gate_lo", o_split_gate_low_gain_path, !sens);
        check("gate_hi", o_split_gate_high_gain_path, sens);
      end
      n++;
      tick(1);
    end
    check("samples", ns, 524);
    // Ten set-up cycles and 524 pixel slots of five cycles each.
    check("line_len", n, 2630);
    run_len(3'b010, 50, "merge2");
    run_len(3'b001, 50, "swap2");
    // The array model registers the row move one edge after phase b falls.
    tick(1);
    check("line_pix", line_pix, 10'h20c);
    check("rows2", rows, 10'h002);
  endtask
  initial begin
    reset_values();
    frame_mode(1'b0);
    frame_mode(1'b1);
    reset_values();
    end_of_test();
  end
endmodule
`default_nettype wire
